// ==== rtl/lintmc_core.sv ====
// single-wire bus transceiver mode control, wake detection and fault supervision
//
// Functional notes
// R1 - off mode after reset, allowed everywhere
// R2 - off mode ignores bus wake-up
// R3 - normal mode only in chip normal/swdev
// R4 - tx low drives bus dominant
// R5 - rx output follows bus state
// R6 - controller keeps tx high during enabling
// R7 - stale dominant blocked; next fresh low sent
// R8 - receive-only: driver off; normal/stop only
// R9 - wake mode selectable; forced in fail-safe
// R10 - wake on release after long dominant
// R11 - rx held low after wake until change
// R12 - mode field still reads wake code
// R13 - rearm by mode toggle or chip mode
// R14 - wake in stop/normal: interrupt, flag, rx
// R15 - controller commands normal after stop wake
// R16 - stop wake enables watchdog if configured
// R17 - sleep/restart/failsafe wake go to restart
// R18 - no interrupt from sleep; source readable
// R19 - tx timeout disables driver, sets failure
// R20 - re-enable after recessive, then enabling time
// R21 - bus dominant timeout sets failure flag
// R22 - undervoltage disables driver and receiver
// R23 - undervoltage keeps selected mode
// R24 - wake filter between 30 and 150 us
// R25 - normal slope default; low slope latched
// R26 - timing as clock counts, parameterised
// R27 - failure flag sticky until software clears
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module lintmc_core
	import lintmc_pkg::*;
#(
	parameter int TX_TO_CYC  = LINTMC_TX_TO_CYC,
	parameter int BUS_TO_CYC = LINTMC_BUS_TO_CYC
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// register port
	input  wire logic [3:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// serial chip select, for deferred slope change
	input  wire logic             spi_csn,
	// chip state
	input  wire lintmc_chip_t     chip_mode,
	input  wire logic             wd_enabled,
	input  wire logic             supply_uv,
	// controller side
	input  wire logic             bus_tx_input,
	output logic                  bus_rx_pin,
	// bus side
	input  wire logic             bus_level,
	output logic                  bus_drive_dom,
	output logic                  low_slope,
	// wake reaction to chip controller
	output lintmc_wake_req_t      wake_req
);

	localparam logic [LINTMC_CNT_W-1:0] EN_MAX   = LINTMC_CNT_W'(LINTMC_EN_TIME_CYC);
	localparam logic [LINTMC_CNT_W-1:0] FILT_MAX = LINTMC_CNT_W'(LINTMC_WAKE_FILT_CYC);
	localparam logic [LINTMC_CNT_W-1:0] TXTO_MAX = LINTMC_CNT_W'(TX_TO_CYC);
	localparam logic [LINTMC_CNT_W-1:0] BUSTO_MAX = LINTMC_CNT_W'(BUS_TO_CYC);

	function automatic logic mode_allowed(lintmc_trx_t m, lintmc_chip_t c);
		case (m)
			LINTMC_TRX_OFF:    mode_allowed = 1'b1;
			LINTMC_TRX_NORMAL: mode_allowed = (c == LINTMC_CHIP_NORMAL) ||
			                                  (c == LINTMC_CHIP_SWDEV);
			LINTMC_TRX_RXONLY: mode_allowed = (c == LINTMC_CHIP_NORMAL) ||
			                                  (c == LINTMC_CHIP_STOP);
			LINTMC_TRX_WAKE:   mode_allowed = (c != LINTMC_CHIP_SWDEV) &&
			                                  (c != LINTMC_CHIP_FAILSAFE);
			default:           mode_allowed = 1'b0;
		endcase
	endfunction : mode_allowed

	function automatic logic is_rearm_mode(lintmc_chip_t c);
		is_rearm_mode = (c == LINTMC_CHIP_STOP) || (c == LINTMC_CHIP_SLEEP) ||
		                (c == LINTMC_CHIP_FAILSAFE);
	endfunction : is_rearm_mode

	typedef enum logic [1:0] {EN_IDLE, EN_WAIT, EN_ARMED, EN_TIMEOUT} lintmc_en_t;

	lintmc_trx_t               mode_reg;
	logic                      slope_pend_reg;
	logic                      low_slope_reg;
	logic                      wd_wake_cfg_reg;
	logic                      wake_flag_reg;
	logic [1:0]                fail_reg;
	logic                      woken_reg;
	lintmc_chip_t              chip_prev_reg;
	lintmc_en_t                en_state_reg;
	logic [LINTMC_CNT_W-1:0]   en_cnt_reg;
	logic [LINTMC_CNT_W-1:0]   txto_cnt_reg;
	logic [LINTMC_CNT_W-1:0]   busto_cnt_reg;
	logic [LINTMC_CNT_W-1:0]   filt_cnt_reg;
	logic                      filt_ok_reg;
	logic                      bus_prev_reg;

	logic          wr_ctrl;
	logic          wr_mode_ok;
	logic          chip_rearm;
	logic          wake_event;
	logic          drv_active;
	logic          tx_timeout;
	logic          bus_clamp;
	lintmc_trx_t   wr_mode;

	assign wr_ctrl    = reg_wr && (reg_addr == LINTMC_ADDR_CTRL);
	assign wr_mode    = lintmc_trx_t'(reg_wdata[LINTMC_CTRL_MODE_LSB +: 2]);
	assign wr_mode_ok = wr_ctrl && mode_allowed(wr_mode, chip_mode); // [R3] [R8] [R9]
	assign chip_rearm = (chip_mode != chip_prev_reg) && is_rearm_mode(chip_mode); // [R13]
	// wake counts only in wake mode with receiver powered
	assign wake_event = (mode_reg == LINTMC_TRX_WAKE) && !woken_reg && !supply_uv &&
	                    filt_ok_reg && !bus_prev_reg && bus_level; // [R2] [R10]
	assign tx_timeout = (txto_cnt_reg == TXTO_MAX);
	assign bus_clamp  = (busto_cnt_reg == BUSTO_MAX);

	// mode register; undervoltage never touches it
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= LINTMC_TRX_OFF; // [R1]
		end else if (chip_mode == LINTMC_CHIP_FAILSAFE && chip_prev_reg != chip_mode) begin
			mode_reg <= LINTMC_TRX_WAKE; // [R9]
		end else if (wr_mode_ok) begin
			mode_reg <= wr_mode; // [R23]
		end
	end

	// woken state: rx held low, cleared on a write that changes the mode or on chip rearm
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			woken_reg <= 1'b0;
		end else if (wake_event) begin
			woken_reg <= 1'b1; // [R11] [R12]
		end else if ((wr_mode_ok && wr_mode != mode_reg) || chip_rearm) begin
			woken_reg <= 1'b0; // [R13]
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			chip_prev_reg <= LINTMC_CHIP_NORMAL;
			bus_prev_reg  <= 1'b1;
		end else begin
			chip_prev_reg <= chip_mode;
			bus_prev_reg  <= bus_level;
		end
	end

	// wake filter: dominant must outlast the minimum filter time
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			filt_cnt_reg <= '0;
			filt_ok_reg  <= 1'b0;
		end else if (bus_level) begin
			filt_cnt_reg <= '0;
			filt_ok_reg  <= 1'b0;
		end else if (filt_cnt_reg == FILT_MAX) begin
			filt_ok_reg  <= 1'b1; // [R24] [R26]
		end else begin
			filt_cnt_reg <= filt_cnt_reg + 1'b1;
		end
	end

	// software settings, slope latched on chip-select release
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			slope_pend_reg  <= LINTMC_CTRL_RESET[LINTMC_CTRL_SLOPE];
			low_slope_reg   <= LINTMC_CTRL_RESET[LINTMC_CTRL_SLOPE]; // [R25]
			wd_wake_cfg_reg <= LINTMC_CTRL_RESET[LINTMC_CTRL_WDWAKE];
		end else begin
			if (wr_ctrl) begin
				wd_wake_cfg_reg <= reg_wdata[LINTMC_CTRL_WDWAKE];
				if (chip_mode == LINTMC_CHIP_NORMAL) begin
					slope_pend_reg <= reg_wdata[LINTMC_CTRL_SLOPE];
				end
			end
			if (spi_csn) begin
				low_slope_reg <= slope_pend_reg; // [R25]
			end
		end
	end

	// wake status: set wins over write-one-to-clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wake_flag_reg <= 1'b0;
		end else if (wake_event) begin
			wake_flag_reg <= 1'b1; // [R14] [R18]
		end else if (reg_wr && reg_addr == LINTMC_ADDR_WKSTAT && reg_wdata[LINTMC_WK_BUS]) begin
			wake_flag_reg <= 1'b0;
		end
	end

	// failure flags sticky, set wins over write-one-to-clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fail_reg <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == LINTMC_FAIL_TXTO) ? tx_timeout : bus_clamp) begin
					fail_reg[i] <= 1'b1; // [R19] [R21]
				end else if (reg_wr && reg_addr == LINTMC_ADDR_FAIL && reg_wdata[i]) begin
					fail_reg[i] <= 1'b0; // [R27]
				end
			end
		end
	end

	// tx dominant timeout counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			txto_cnt_reg <= '0;
		end else if (bus_tx_input || mode_reg != LINTMC_TRX_NORMAL) begin
			txto_cnt_reg <= '0;
		end else if (!tx_timeout) begin
			txto_cnt_reg <= txto_cnt_reg + 1'b1; // [R26]
		end
	end

	// bus clamp counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busto_cnt_reg <= '0;
		end else if (bus_level || mode_reg == LINTMC_TRX_OFF || supply_uv) begin
			busto_cnt_reg <= '0;
		end else if (!bus_clamp) begin
			busto_cnt_reg <= busto_cnt_reg + 1'b1;
		end
	end

	// enabling sequence; restarted by mode entry, uv recovery and timeout release
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_state_reg <= EN_IDLE;
			en_cnt_reg   <= '0;
		end else if (mode_reg != LINTMC_TRX_NORMAL || supply_uv) begin
			en_state_reg <= EN_IDLE; // [R22]
			en_cnt_reg   <= '0;
		end else begin
			case (en_state_reg)
				EN_IDLE: begin
					en_state_reg <= EN_WAIT;
					en_cnt_reg   <= '0;
				end
				EN_WAIT: begin
					if (en_cnt_reg == EN_MAX) begin
						en_state_reg <= EN_ARMED;
					end else begin
						en_cnt_reg <= en_cnt_reg + 1'b1;
					end
				end
				EN_ARMED: begin
					if (tx_timeout) begin
						en_state_reg <= EN_TIMEOUT; // [R19]
					end
				end
				EN_TIMEOUT: begin
					if (bus_tx_input) begin
						en_state_reg <= EN_IDLE; // [R20]
					end
				end
				default: en_state_reg <= EN_IDLE;
			endcase
		end
	end

	// driver gate: a low already present at arming is held off until tx goes high
	logic fresh_reg;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fresh_reg <= 1'b0;
		end else if (en_state_reg != EN_ARMED) begin
			fresh_reg <= 1'b0;
		end else if (bus_tx_input) begin
			fresh_reg <= 1'b1; // [R7]
		end
	end

	// mode and supply gate directly, so the registered driver output drops at the first clock edge after they change
	assign drv_active = (en_state_reg == EN_ARMED) && fresh_reg && !tx_timeout &&
	                    (mode_reg == LINTMC_TRX_NORMAL) && !supply_uv; // [R8] [R22]

	// outputs from flip-flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_drive_dom <= 1'b0;
			bus_rx_pin    <= 1'b1;
			wake_req      <= '{irq_n: 1'b1, to_restart: 1'b0, wd_enable: 1'b0};
		end else begin
			bus_drive_dom <= drv_active && !bus_tx_input; // [R4] [R8] [R22]
			if (woken_reg || wake_event) begin
				bus_rx_pin <= 1'b0; // [R11]
			end else if (mode_reg == LINTMC_TRX_NORMAL || mode_reg == LINTMC_TRX_RXONLY) begin
				bus_rx_pin <= supply_uv ? 1'b1 : bus_level; // [R5] [R22]
			end else begin
				bus_rx_pin <= 1'b1;
			end
			wake_req.irq_n <= !(wake_event && (chip_mode == LINTMC_CHIP_STOP ||
			                   chip_mode == LINTMC_CHIP_NORMAL)); // [R14] [R18]
			wake_req.to_restart <= wake_event && (chip_mode == LINTMC_CHIP_SLEEP ||
			                       chip_mode == LINTMC_CHIP_RESTART ||
			                       chip_mode == LINTMC_CHIP_FAILSAFE); // [R17]
			wake_req.wd_enable <= wake_event && chip_mode == LINTMC_CHIP_STOP &&
			                      !wd_enabled && wd_wake_cfg_reg; // [R16]
		end
	end

	assign low_slope = low_slope_reg;

	// register read, data valid the cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				LINTMC_ADDR_CTRL:   reg_rdata <= {4'h0, wd_wake_cfg_reg, slope_pend_reg,
				                                  mode_reg}; // [R12]
				LINTMC_ADDR_WKSTAT: reg_rdata <= {7'h00, wake_flag_reg};
				LINTMC_ADDR_FAIL:   reg_rdata <= {6'h00, fail_reg};
				LINTMC_ADDR_STATUS: reg_rdata <= {4'h0, woken_reg, drv_active, low_slope_reg,
				                                  supply_uv};
				default:            reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	AST_OFF_AT_RESET: assert property (@(posedge core_clk) $rose(rstn) |-> // [R1]
		mode_reg == LINTMC_TRX_OFF) else $error("mode not off after reset");
	AST_OFF_NO_WAKE: assert property (@(posedge core_clk) disable iff (!rstn) // [R2]
		$past(mode_reg) == LINTMC_TRX_OFF |-> wake_req.irq_n && !wake_req.to_restart)
		else $error("wake reaction in off mode");
	AST_NORMAL_GATE: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
		$changed(mode_reg) && mode_reg == LINTMC_TRX_NORMAL |->
		$past(chip_mode) inside {LINTMC_CHIP_NORMAL, LINTMC_CHIP_SWDEV})
		else $error("normal mode entered in wrong chip mode");
	AST_NO_DRIVE_TX_HIGH: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
		$past(bus_tx_input) |-> !bus_drive_dom) else $error("dominant with tx high");
	AST_RXONLY_NO_DRV: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
		$past(mode_reg) == LINTMC_TRX_RXONLY |-> !bus_drive_dom)
		else $error("driver on in receive-only");
	AST_WAKE_RX_LOW: assert property (@(posedge core_clk) disable iff (!rstn) // [R11]
		wake_event |=> !bus_rx_pin [*2]) else $error("rx not held low after wake");
	AST_STOP_IRQ: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
		wake_event && chip_mode == LINTMC_CHIP_STOP |=> !wake_req.irq_n)
		else $error("no interrupt on stop wake");
	AST_SLEEP_NO_IRQ: assert property (@(posedge core_clk) disable iff (!rstn) // [R17] [R18]
		wake_event && chip_mode == LINTMC_CHIP_SLEEP |=> wake_req.irq_n && wake_req.to_restart)
		else $error("wrong sleep wake reaction");
	AST_TXTO_FAIL: assert property (@(posedge core_clk) disable iff (!rstn) // [R19]
		tx_timeout |=> fail_reg[LINTMC_FAIL_TXTO] && !bus_drive_dom)
		else $error("tx timeout not handled");
	AST_UV_NO_DRV: assert property (@(posedge core_clk) disable iff (!rstn) // [R22]
		supply_uv |=> !bus_drive_dom) else $error("driver on in undervoltage");

	COV_WAKE: cover property (@(posedge core_clk) disable iff (!rstn) wake_event);
	COV_DOMINANT: cover property (@(posedge core_clk) disable iff (!rstn) bus_drive_dom);
	COV_TXTO: cover property (@(posedge core_clk) disable iff (!rstn) tx_timeout);
	COV_CLAMP: cover property (@(posedge core_clk) disable iff (!rstn) bus_clamp);

endmodule : lintmc_core

// ==== rtl/lintmc_pkg.sv ====
// package: constants and types for the single-wire bus transceiver mode control
package lintmc_pkg;

	// transceiver mode field codes (wake-capable reads 01)
	typedef enum logic [1:0] {
		LINTMC_TRX_OFF    = 2'h0,
		LINTMC_TRX_WAKE   = 2'h1,
		LINTMC_TRX_RXONLY = 2'h2,
		LINTMC_TRX_NORMAL = 2'h3
	} lintmc_trx_t;

	// chip operating modes seen by this block
	typedef enum logic [2:0] {
		LINTMC_CHIP_NORMAL   = 3'h0,
		LINTMC_CHIP_STOP     = 3'h1,
		LINTMC_CHIP_SLEEP    = 3'h2,
		LINTMC_CHIP_RESTART  = 3'h3,
		LINTMC_CHIP_FAILSAFE = 3'h4,
		LINTMC_CHIP_SWDEV    = 3'h5
	} lintmc_chip_t;

	// wake request towards the chip mode controller
	typedef struct packed {
		logic irq_n;
		logic to_restart;
		logic wd_enable;
	} lintmc_wake_req_t;

	// register map
	localparam logic [3:0] LINTMC_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] LINTMC_ADDR_WKSTAT = 4'h1;
	localparam logic [3:0] LINTMC_ADDR_FAIL   = 4'h2;
	localparam logic [3:0] LINTMC_ADDR_STATUS = 4'h3;

	// control register fields
	localparam int LINTMC_CTRL_MODE_LSB = 0;
	localparam int LINTMC_CTRL_SLOPE    = 2;
	localparam int LINTMC_CTRL_WDWAKE   = 3;
	// wake status / failure fields
	localparam int LINTMC_WK_BUS        = 0;
	localparam int LINTMC_FAIL_TXTO     = 0;
	localparam int LINTMC_FAIL_CLAMP    = 1;

	localparam logic [7:0] LINTMC_CTRL_RESET = 8'h00;

	// timing
	localparam int LINTMC_CLK_MHZ       = 200;
	localparam int LINTMC_WAKE_FILT_US  = 30;
	localparam int LINTMC_EN_TIME_US    = 10;
	localparam int LINTMC_TX_TO_MS      = 4;
	localparam int LINTMC_BUS_TO_MS     = 4;
	localparam int LINTMC_WAKE_FILT_CYC = LINTMC_WAKE_FILT_US * LINTMC_CLK_MHZ;
	localparam int LINTMC_EN_TIME_CYC   = LINTMC_EN_TIME_US * LINTMC_CLK_MHZ;
	localparam int LINTMC_TX_TO_CYC     = LINTMC_TX_TO_MS * 1000 * LINTMC_CLK_MHZ;
	localparam int LINTMC_BUS_TO_CYC    = LINTMC_BUS_TO_MS * 1000 * LINTMC_CLK_MHZ;
	localparam int LINTMC_CNT_W         = 20;

endpackage : lintmc_pkg

// ==== verif/lintmc_core_tb_top.sv ====
// self-checking bench for the transceiver mode control core
`timescale 1ns/1ps

module lintmc_core_tb_top
	import lintmc_pkg::*;
;
	// above the enabling time, so a low held while enabling never trips it
	localparam int TO_CYC = 2500;
	localparam lintmc_chip_t CHIPS [5] = '{LINTMC_CHIP_NORMAL, LINTMC_CHIP_STOP,
		LINTMC_CHIP_SLEEP, LINTMC_CHIP_RESTART, LINTMC_CHIP_SWDEV};

	logic             core_clk  = 1'b0;
	logic             rstn      = 1'b0;
	logic [3:0]       reg_addr  = 4'h0;
	logic [7:0]       reg_wdata = 8'h00;
	logic             reg_wr    = 1'b0;
	logic             reg_rd    = 1'b0;
	logic             spi_csn   = 1'b1;
	lintmc_chip_t     chip_mode = LINTMC_CHIP_NORMAL;
	logic             supply_uv = 1'b0;
	logic             arm = 1'b0, early = 1'b0, bit_req = 1'b1, ext_dom = 1'b0;
	logic [7:0]       reg_rdata, seed = 8'h52;
	logic             bus_tx_input, bus_rx_pin, bus_level, bus_drive_dom, low_slope;
	lintmc_wake_req_t wake_req;
	logic             saw_irq, saw_rst, saw_wd, clr_req = 1'b0, wd_en = 1'b0;
	int               bad_count = 0, samples_checked = 0;

	always #2.5 core_clk = ~core_clk;
	// pulled-up wire: dominant if any party pulls it
	assign bus_level = !(bus_drive_dom || ext_dom);

	// sticky wake observations, emptied in reset and on request
	always @(posedge core_clk) begin
		if (!rstn || clr_req) begin
			saw_irq <= 1'b0;
			saw_rst <= 1'b0;
			saw_wd  <= 1'b0;
		end else begin
			saw_irq <= saw_irq | !wake_req.irq_n;
			saw_rst <= saw_rst | wake_req.to_restart;
			saw_wd  <= saw_wd | wake_req.wd_enable;
		end
	end

	lintmc_core #(.TX_TO_CYC(TO_CYC), .BUS_TO_CYC(TO_CYC)) lintmc_core_inst (
		.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_csn(spi_csn),
		.chip_mode(chip_mode), .wd_enabled(wd_en), .supply_uv(supply_uv),
		.bus_tx_input(bus_tx_input), .bus_rx_pin(bus_rx_pin), .bus_level(bus_level),
		.bus_drive_dom(bus_drive_dom), .low_slope(low_slope), .wake_req(wake_req));

	lintmc_mcu_model lintmc_mcu_model_inst (
		.core_clk(core_clk), .rstn(rstn), .arm(arm), .early(early),
		.bit_req(bit_req), .tx(bus_tx_input));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function automatic logic mode_ok(input lintmc_chip_t c, input lintmc_trx_t m);
		case (m)
			LINTMC_TRX_WAKE:   return c <= LINTMC_CHIP_RESTART;
			LINTMC_TRX_RXONLY: return c <= LINTMC_CHIP_STOP;
			LINTMC_TRX_NORMAL: return c == LINTMC_CHIP_NORMAL || c == LINTMC_CHIP_SWDEV;
			default:           return 1'b1;
		endcase
	endfunction : mode_ok

	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata & m, exp);
	endtask : rchk

	task automatic set_chip(input lintmc_chip_t c);
		@(posedge core_clk);
		chip_mode <= c;
	endtask : set_chip

	task automatic clr;
		clr_req <= 1'b1;
		@(posedge core_clk);
		clr_req <= 1'b0;
	endtask : clr

	task automatic dom(input int n);
		@(posedge core_clk);
		ext_dom <= 1'b1;
		cyc(n);
		ext_dom <= 1'b0;
	endtask : dom

	// the wake reaction must show within a few cycles of the bus release
	task automatic wait_seen(input logic want_rst);
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			#1;
			if (want_rst ? saw_rst : saw_irq) break;
		end
		if (i == 20) begin
			bad_count++;
			close_out();
		end
	endtask : wait_seen

	initial begin
		cyc(3);
		rstn <= 1'b1;
		rchk(LINTMC_ADDR_CTRL, 8'h03, 8'h00);
		rchk(4'hf, 8'hff, 8'h00);
		chk1(bus_rx_pin, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			for (int m = 0; m < 4; m++) begin
				set_chip(CHIPS[i]);
				wr(LINTMC_ADDR_CTRL, 8'h00);
				wr(LINTMC_ADDR_CTRL, 8'(m));
				rchk(LINTMC_ADDR_CTRL, 8'h03, mode_ok(CHIPS[i], lintmc_trx_t'(m)) ? 8'(m) : 8'h00);
			end
		end
		$display("test mode table done");
		wr(LINTMC_ADDR_CTRL, 8'h00);
		set_chip(LINTMC_CHIP_NORMAL);
		early   <= 1'b1;
		bit_req <= 1'b0;
		wr(LINTMC_ADDR_CTRL, 8'h03);
		cyc(2010);
		#1;
		chk1(bus_drive_dom, 1'b0);
		@(posedge core_clk);
		bit_req <= 1'b1;
		early   <= 1'b0;
		cyc(2);
		bit_req <= 1'b0;
		cyc(2);
		#1;
		chk1(bus_drive_dom, 1'b1);
		chk1(bus_rx_pin, 1'b0);
		$display("test enabling done");
		for (int k = 0; k < 32; k++) begin
			@(posedge core_clk);
			seed = lfsr(seed);
			bit_req <= seed[0];
			@(posedge core_clk);
			#1;
			chk1(bus_drive_dom, !seed[0]);
		end
		$display("test random bits done");
		@(posedge core_clk);
		bit_req <= 1'b0;
		cyc(TO_CYC + 20);
		#1;
		chk1(bus_drive_dom, 1'b0);
		rchk(LINTMC_ADDR_FAIL, 8'h01, 8'h01);
		bit_req <= 1'b1;
		cyc(500);
		bit_req <= 1'b0;
		cyc(50);
		#1;
		chk1(bus_drive_dom, 1'b0);
		@(posedge core_clk);
		bit_req <= 1'b1;
		cyc(1600);
		bit_req <= 1'b0;
		cyc(2);
		#1;
		chk1(bus_drive_dom, 1'b1);
		bit_req <= 1'b1;
		rchk(LINTMC_ADDR_FAIL, 8'h01, 8'h01);
		wr(LINTMC_ADDR_FAIL, 8'h03);
		rchk(LINTMC_ADDR_FAIL, 8'h03, 8'h00);
		dom(TO_CYC + 20);
		rchk(LINTMC_ADDR_FAIL, 8'h02, 8'h02);
		wr(LINTMC_ADDR_FAIL, 8'h02);
		$display("test timeouts done");
		@(posedge core_clk);
		supply_uv <= 1'b1;
		bit_req   <= 1'b0;
		ext_dom   <= 1'b1;
		cyc(3);
		#1;
		chk1(bus_drive_dom, 1'b0);
		chk1(bus_rx_pin, 1'b1);
		ext_dom <= 1'b0;
		bit_req <= 1'b1;
		rchk(LINTMC_ADDR_CTRL, 8'h03, 8'h03);
		rchk(LINTMC_ADDR_STATUS, 8'h05, 8'h01);
		@(posedge core_clk);
		supply_uv <= 1'b0;
		arm       <= 1'b1;
		@(posedge core_clk);
		arm <= 1'b0;
		cyc(100);
		early   <= 1'b1;
		bit_req <= 1'b0;
		cyc(3);
		#1;
		chk1(bus_drive_dom, 1'b0);
		@(posedge core_clk);
		early <= 1'b0;
		cyc(2000);
		#1;
		chk1(bus_drive_dom, 1'b1);
		@(posedge core_clk);
		bit_req <= 1'b1;
		$display("test undervoltage done");
		spi_csn <= 1'b0;
		wr(LINTMC_ADDR_CTRL, 8'h07);
		cyc(3);
		#1;
		chk1(low_slope, 1'b0);
		spi_csn <= 1'b1;
		cyc(3);
		#1;
		chk1(low_slope, 1'b1);
		$display("test slope done");
		wr(LINTMC_ADDR_CTRL, 8'h00);
		dom(6100);
		cyc(5);
		#1;
		chk1(bus_rx_pin, 1'b1);
		rchk(LINTMC_ADDR_WKSTAT, 8'h01, 8'h00);
		set_chip(LINTMC_CHIP_STOP);
		wr(LINTMC_ADDR_CTRL, 8'h09);
		clr();
		dom(1000);
		cyc(5);
		#1;
		chk1(bus_rx_pin, 1'b1);
		dom(6100);
		wait_seen(1'b0);
		chk1(saw_wd, 1'b1);
		chk1(saw_rst, 1'b0);
		cyc(100);
		#1;
		chk1(bus_rx_pin, 1'b0);
		rchk(LINTMC_ADDR_WKSTAT, 8'h01, 8'h01);
		rchk(LINTMC_ADDR_CTRL, 8'h03, 8'h01);
		wr(LINTMC_ADDR_CTRL, 8'h09);
		cyc(2);
		#1;
		chk1(bus_rx_pin, 1'b0);
		set_chip(LINTMC_CHIP_NORMAL);
		wr(LINTMC_ADDR_CTRL, 8'h03);
		cyc(3);
		#1;
		chk1(bus_rx_pin, 1'b1);
		wr(LINTMC_ADDR_WKSTAT, 8'h01);
		set_chip(LINTMC_CHIP_STOP);
		wr(LINTMC_ADDR_CTRL, 8'h09);
		wd_en <= 1'b1;
		clr();
		dom(6100);
		wait_seen(1'b0);
		chk1(saw_wd, 1'b0);
		$display("test stop wake done");
		wr(LINTMC_ADDR_WKSTAT, 8'h01);
		set_chip(LINTMC_CHIP_SLEEP);
		clr();
		dom(6100);
		wait_seen(1'b1);
		chk1(saw_irq, 1'b0);
		cyc(2);
		#1;
		chk1(bus_rx_pin, 1'b0);
		rchk(LINTMC_ADDR_WKSTAT, 8'h01, 8'h01);
		set_chip(LINTMC_CHIP_RESTART);
		wr(LINTMC_ADDR_CTRL, 8'h00);
		set_chip(LINTMC_CHIP_FAILSAFE);
		cyc(3);
		rchk(LINTMC_ADDR_CTRL, 8'h03, 8'h01);
		$display("test sleep and fail-safe done");
		close_out();
	end
endmodule : lintmc_core_tb_top

// ==== verif/lintmc_mcu_model.sv ====
// partner model: controller side that drives the transmit input
`timescale 1ns/1ps

module lintmc_mcu_model
	import lintmc_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// bench control: arm starts the hold, early breaks it on purpose
	input  wire logic arm,
	input  wire logic early,
	input  wire logic bit_req,
	// transmit pin
	output logic      tx
);
	logic [11:0] hold_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hold_reg <= 12'h000;
		end else if (arm) begin
			hold_reg <= 12'(LINTMC_EN_TIME_CYC + 4);
		end else if (hold_reg != 12'h000) begin
			hold_reg <= hold_reg - 12'h001;
		end
	end

	// a little margin past the enabling time, since arming is seen late
	assign tx = (hold_reg != 12'h000 && !early) ? 1'b1 : bit_req;
endmodule : lintmc_mcu_model
